//--- sep_pin_if.sv
// Carrier between the register block and the pin router.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface sep_pin_if;
  import sep_pkg::*;
  sep_pins_t func_sel;
  sep_pins_t ctl_out;
  sep_pins_t ctl_oe;
  sep_pins_t ctl_in;
  sep_pins_t gpio_out;
  sep_pins_t gpio_oe;
  sep_pins_t gpio_in;
  sep_pins_t pin_in;
  sep_pins_t pin_out;
  sep_pins_t pin_oe;

  modport top (
    output func_sel, ctl_out, ctl_oe, gpio_out, gpio_oe, pin_in,
    input ctl_in, gpio_in, pin_out, pin_oe
  );
  modport route (
    input func_sel, ctl_out, ctl_oe, gpio_out, gpio_oe, pin_in,
    output ctl_in, gpio_in, pin_out, pin_oe
  );
endinterface

`default_nettype wire

//--- sep_pin_route.sv
// Pin router: hands each serial pin to the controller or to GPIO.
// Assumes pin inputs are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"

module sep_pin_route
  import sep_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  sep_pin_if.route pif
);

  // Registered drive keeps the pads free of mux glitches
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pif.pin_out <= '0;
      pif.pin_oe <= '0;
    end else begin
      pif.pin_out <= (pif.func_sel & pif.ctl_out) | (~pif.func_sel & pif.gpio_out);
      pif.pin_oe <= (pif.func_sel & pif.ctl_oe) | (~pif.func_sel & pif.gpio_oe);
    end
  end

  // GPIO-owned pins look idle high to the controller; GPIO sees all
  assign pif.ctl_in = pif.pin_in | ~pif.func_sel;
  assign pif.gpio_in = pif.pin_in;

  property p_route_oe;
    @(posedge clk_i) disable iff (!rstn_i)
      1'b1 |=> pif.pin_oe == (($past(pif.func_sel) & $past(pif.ctl_oe))
                           | (~$past(pif.func_sel) & $past(pif.gpio_oe)));
  endproperty
  a_route_oe: assert property (p_route_oe)
    else $error("pin enable not taken from selected owner");

  property p_gpio_blind;
    @(posedge clk_i) disable iff (!rstn_i)
      !pif.func_sel[`SEP_PF_ENA] |-> pif.ctl_in[`SEP_PF_ENA];
  endproperty
  a_gpio_blind: assert property (p_gpio_blind)
    else $error("controller sees a GPIO-owned handshake pin");

endmodule

`default_nettype wire

//--- sep_pkg.sv
// Types shared by the flag and pin function block.
// Holds no constants; those sit in sep_regs.svh.
package sep_pkg;

  // Handshake monitor states, Gray coded along idle-wait-run-abort
  typedef enum logic [1:0] {
    SEP_IDLE = 2'h0,
    SEP_WAIT = 2'h1,
    SEP_RUN = 2'h3,
    SEP_ABORT = 2'h2
  } sep_hsk_e;

  // One bit per routed pin: 7..0 chip selects, 8 handshake, 9 clock,
  // 10 slave-in, 11 slave-out
  typedef logic [11:0] sep_pins_t;

endpackage

//--- sep_regs.svh
// Offsets, field positions, reset values and timing figures of the
// serial controller flag and pin function block.
// Included by the pin router, the top level and the bench; definitions only.
// Contract
// - Parity flag reads 0 with no parity mismatch, 1 once one occurred.
// - Handshake time-out is checked only as master, never raised as slave.
// - As master, time-out when slave handshake stays inactive past allowed time.
// - On time-out release that chip select at once and set the flag.
// - Time-out flag reads 0 with no time-out, 1 after one occurred.
// - Length error flag reads 0 with no length error, 1 once one occurred.
// - Writing one to a flag bit clears only that flag.
// - Global enable at 0 clears all three error flags.
// - Pin function bits 31 down to 12 are read-only zero.
// - Bit 11 slave-out, 10 slave-in, 9 serial clock, 8 handshake pin.
// - Function bit 0 gives pin to GPIO, 1 to the serial controller.
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH

// Byte offsets on the bus
`define SEP_OFF_GCTL 8'h04
`define SEP_OFF_ERR 8'h10
`define SEP_OFF_PINF 8'h14
`define SEP_OFF_ISTS 8'h20
`define SEP_OFF_IMSK 8'h24

// Second global control register fields
`define SEP_GCTL_MASTER 0
`define SEP_GCTL_EN 1
`define SEP_GCTL_RST 2'h0

// Error flag positions; interrupt status and mask share them
`define SEP_ERR_PAR 2
`define SEP_ERR_TMO 1
`define SEP_ERR_LEN 0
`define SEP_ERR_RST 3'h0

// Pin function fields
`define SEP_PF_SOMI 11
`define SEP_PF_SIMO 10
`define SEP_PF_CLK 9
`define SEP_PF_ENA 8
`define SEP_PF_RST 12'h000

// Handshake allowed time and clock rate
`define SEP_HSK_TMO_NS 2000
`define SEP_CLK_MHZ 25

`endif

//--- sep_slave_model.sv
// Behavioural serial slave on the far side of the link.
// Assumes the handshake line has a pull-up on the board.
`timescale 1ns/1ps
`default_nettype none

module sep_slave_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic answer_i,
  output logic hsk_n_o,
  output logic hsk_oe_o
);
  logic [1:0] dly_ff;

  // Answers two cycles after select; releases the line otherwise
  always_ff @(posedge clk_i) begin
    if (!rstn_i || cs_n_i || !answer_i) begin
      dly_ff <= 2'h0;
    end else if (dly_ff != 2'h2) begin
      dly_ff <= dly_ff + 2'h1;
    end
  end

  // Released line is left to the pull-up, never held at the old level
  assign hsk_oe_o = (dly_ff == 2'h2);
  assign hsk_n_o = 1'b0;
endmodule

`default_nettype wire

//--- sep_top.sv
// Error flags, handshake time-out monitor and pin function select of
// the serial controller, reached over a classic Wishbone slave.
// Assumes the shift engine pulses its error events for one cycle and
// holds its chip select request while it wants the slave.
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"

module sep_top
  import sep_pkg::*;
#(
  parameter int TMO_CYC = (`SEP_HSK_TMO_NS * `SEP_CLK_MHZ) / 1000
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic parity_err_i,
  input wire logic length_err_i,
  input wire logic [7:0] cs_req_i,
  output logic hsk_ready_o,
  output logic master_o,
  output logic enable_o,
  input wire logic [3:0] eng_out_i,
  input wire logic [3:0] eng_oe_i,
  output logic [11:0] eng_in_o,
  input wire logic [11:0] gpio_out_i,
  input wire logic [11:0] gpio_oe_i,
  output logic [11:0] gpio_in_o,
  input wire logic [11:0] pin_i,
  output logic [11:0] pin_o,
  output logic [11:0] pin_oe_o
);

  // A zero or oversized allowed time cannot be counted
  if (TMO_CYC < 1 || TMO_CYC > 65535) begin : g_chk
    $error("TMO_CYC must lie in 1..65535");
  end

  localparam logic [15:0] TmoLast = 16'(TMO_CYC - 1);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sep_pin_if pif ();

  logic ack_ff;
  logic req;
  logic wr_en;
  logic rd_done;
  logic [31:0] wmask;
  logic [7:0] adr_w;
  logic hit_gctl;
  logic hit_err;
  logic hit_pinf;
  logic hit_ists;
  logic hit_imsk;
  logic [1:0] gctl_ff;
  logic [11:0] pinf_ff;
  logic [2:0] err_ff;
  logic [2:0] nxt_err;
  logic [2:0] ists_ff;
  logic [2:0] nxt_ists;
  logic [2:0] imsk_ff;
  logic [2:0] w1c;
  logic [2:0] evt;
  logic [31:0] rdata;
  logic [31:0] dat_ff;
  logic master;
  logic en;
  sep_hsk_e state_ff;
  sep_hsk_e nxt_state;
  logic [7:0] sel_ff;
  logic [7:0] nxt_sel;
  logic [15:0] cnt_ff;
  logic [7:0] cs_n_ff;
  logic cs_any;
  logic use_ena;
  logic ena_act;
  logic tmo_evt;

  // Bus decode; the master keeps the request up until ack
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & ack_ff;
  assign rd_done = req & ~wb_we_i & ack_ff;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign adr_w = {wb_adr_i[7:2], 2'h0};
  assign hit_gctl = (adr_w == `SEP_OFF_GCTL);
  assign hit_err = (adr_w == `SEP_OFF_ERR);
  assign hit_pinf = (adr_w == `SEP_OFF_PINF);
  assign hit_ists = (adr_w == `SEP_OFF_ISTS);
  assign hit_imsk = (adr_w == `SEP_OFF_IMSK);

  // One wait state, ack for exactly one cycle per request
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Second global control: master select and global enable
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gctl_ff <= `SEP_GCTL_RST;
    end else if (wr_en && hit_gctl) begin
      gctl_ff <= (gctl_ff & ~wmask[1:0]) | (wb_dat_i[1:0] & wmask[1:0]);
    end
  end

  assign master = gctl_ff[`SEP_GCTL_MASTER];
  assign en = gctl_ff[`SEP_GCTL_EN];

  // Pin function select; only bits 11..0 have storage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pinf_ff <= `SEP_PF_RST;
    end else if (wr_en && hit_pinf) begin
      pinf_ff <= (pinf_ff & ~wmask[11:0]) | (wb_dat_i[11:0] & wmask[11:0]);
    end
  end

  // Handshake monitor: decides when the slave took too long
  assign cs_any = |cs_req_i;
  assign use_ena = pinf_ff[`SEP_PF_ENA];
  assign ena_act = ~pif.ctl_in[`SEP_PF_ENA]; // Handshake is active low
  assign tmo_evt = en && master && (state_ff == SEP_WAIT) && cs_any && use_ena && !ena_act
                   && (cnt_ff == TmoLast);

  // Next state; leaving master or enable drops everything
  always_comb begin
    nxt_state = state_ff;
    nxt_sel = sel_ff;
    if (!en || !master) begin
      nxt_state = SEP_IDLE;
    end else begin
      case (state_ff)
        SEP_IDLE: begin
          if (cs_any) begin
            nxt_state = SEP_WAIT;
            nxt_sel = cs_req_i;
          end
        end
        SEP_WAIT: begin
          if (!cs_any) begin
            nxt_state = SEP_IDLE;
          end else if (ena_act || !use_ena) begin
            nxt_state = SEP_RUN;
          end else if (tmo_evt) begin
            nxt_state = SEP_ABORT;
          end
        end
        SEP_RUN: begin
          if (!cs_any) begin
            nxt_state = SEP_IDLE;
          end
        end
        SEP_ABORT: begin
          if (!cs_any) begin
            nxt_state = SEP_IDLE;
          end
        end
        default: begin
          nxt_state = SEP_IDLE;
        end
      endcase
    end
  end

  // State and latched chip select choice
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_ff <= SEP_IDLE;
      sel_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      sel_ff <= nxt_sel;
    end
  end

  // Wait counter restarts on every fresh chip select
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_ff <= 16'h0000;
    end else if (state_ff == SEP_WAIT && nxt_state == SEP_WAIT) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end else begin
      cnt_ff <= 16'h0000;
    end
  end

  // Chip selects, active low; released in the same edge as the abort
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cs_n_ff <= 8'hFF;
    end else if (nxt_state == SEP_WAIT || nxt_state == SEP_RUN) begin
      cs_n_ff <= ~nxt_sel;
    end else begin
      cs_n_ff <= 8'hFF;
    end
  end

  // Events; none while disabled so a disable cannot race a set
  assign evt[`SEP_ERR_PAR] = parity_err_i & en;
  assign evt[`SEP_ERR_TMO] = tmo_evt;
  assign evt[`SEP_ERR_LEN] = length_err_i & en;
  assign w1c = (wr_en && hit_err) ? (wb_dat_i[2:0] & wmask[2:0]) : 3'h0;

  // Sticky error flags; a new event beats a clearing write
  always_comb begin
    if (!en) begin
      nxt_err = 3'h0;
    end else begin
      nxt_err = (err_ff & ~w1c) | evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      err_ff <= `SEP_ERR_RST;
    end else begin
      err_ff <= nxt_err;
    end
  end

  // Interrupt status, cleared by a read; a coinciding event survives
  always_comb begin
    nxt_ists = ists_ff;
    if (rd_done && hit_ists) begin
      nxt_ists = 3'h0;
    end
    nxt_ists = nxt_ists | evt;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ists_ff <= 3'h0;
      imsk_ff <= 3'h0;
    end else begin
      ists_ff <= nxt_ists;
      if (wr_en && hit_imsk) begin
        imsk_ff <= (imsk_ff & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
      end
    end
  end

  assign irq_o = |(ists_ff & imsk_ff);

  // Read mux; unmapped words read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_gctl) begin
      rdata[1:0] = gctl_ff;
    end else if (hit_err) begin
      rdata[2:0] = err_ff;
    end else if (hit_pinf) begin
      rdata[11:0] = pinf_ff;
    end else if (hit_ists) begin
      rdata[2:0] = ists_ff;
    end else if (hit_imsk) begin
      rdata[2:0] = imsk_ff;
    end
  end

  // Read data captured in the wait state, stable while ack is up
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (req && !ack_ff) begin
      dat_ff <= rdata;
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;

  // Pin routing: chip selects driven only as master, handshake
  // driven by the engine only as slave
  assign pif.func_sel = pinf_ff;
  assign pif.ctl_out = {eng_out_i, cs_n_ff};
  assign pif.ctl_oe = {eng_oe_i & {3'h7, ~master}, {8{master}}};
  assign pif.gpio_out = gpio_out_i;
  assign pif.gpio_oe = gpio_oe_i;
  assign pif.pin_in = pin_i;

  sep_pin_route u_route (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pif(pif)
  );

  assign eng_in_o = pif.ctl_in;
  assign gpio_in_o = pif.gpio_in;
  assign pin_o = pif.pin_out;
  assign pin_oe_o = pif.pin_oe;
  assign hsk_ready_o = (state_ff == SEP_RUN);
  assign master_o = master;
  assign enable_o = en;

  property p_par_set;
    parity_err_i && en |=> err_ff[`SEP_ERR_PAR];
  endproperty
  a_par_set: assert property (p_par_set)
    else $error("parity event did not set its flag");

  property p_no_slave_tmo;
    !master |=> !$rose(err_ff[`SEP_ERR_TMO]);
  endproperty
  a_no_slave_tmo: assert property (p_no_slave_tmo)
    else $error("time-out flag rose in slave operation");

  property p_tmo_late;
    $rose(err_ff[`SEP_ERR_TMO]) |-> $past(cnt_ff) == TmoLast;
  endproperty
  a_tmo_late: assert property (p_tmo_late)
    else $error("time-out raised before the allowed time");

  property p_tmo_release;
    tmo_evt |=> cs_n_ff == 8'hFF && err_ff[`SEP_ERR_TMO] && state_ff == SEP_ABORT;
  endproperty
  a_tmo_release: assert property (p_tmo_release)
    else $error("chip select not released with time-out flag");

  property p_err_read;
    req && !wb_we_i && !ack_ff && hit_err
      |=> wb_ack_o && wb_dat_o[2:0] == $past(err_ff) && wb_dat_o[31:3] == 29'h0;
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("flag read does not show flag state");

  property p_len_set;
    length_err_i && en |=> err_ff[`SEP_ERR_LEN];
  endproperty
  a_len_set: assert property (p_len_set)
    else $error("length event did not set its flag");

  property p_w1c;
    wr_en && hit_err && wb_sel_i[0] && wb_dat_i[`SEP_ERR_PAR] && !parity_err_i
      && !wb_dat_i[`SEP_ERR_LEN] && err_ff[`SEP_ERR_LEN]
      |=> !err_ff[`SEP_ERR_PAR] && err_ff[`SEP_ERR_LEN];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write-one clear hit the wrong flags");

  property p_disable_clr;
    !en |=> err_ff == 3'h0;
  endproperty
  a_disable_clr: assert property (p_disable_clr)
    else $error("flags survived a disabled controller");

  property p_pinf_read;
    req && !wb_we_i && !ack_ff && hit_pinf
      |=> wb_dat_o[31:12] == 20'h0_0000 && wb_dat_o[11:0] == $past(pinf_ff);
  endproperty
  a_pinf_read: assert property (p_pinf_read)
    else $error("pin function read shows reserved bits");
  property p_sticky;
    en && length_err_i && wr_en && hit_err && wb_sel_i[0] && wb_dat_i[`SEP_ERR_LEN]
      |=> err_ff[`SEP_ERR_LEN];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("length flag lost against a clearing write");

endmodule

`default_nettype wire

//--- test_sep_top.sv
// Self-checking bench for the flag and pin function block.
// Assumes a Wishbone slave with one wait state, time-out shortened to 4.
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"

module test_sep_top;
  localparam int TMO = 4;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic ack, irq, rdy, mst, en, answer = 1'b0, hsk_n, hsk_oe;
  logic par = 1'b0, len = 1'b0;
  logic [7:0] csq = 8'h00;
  logic [3:0] eo = 4'h0, eoe = 4'h0;
  logic [11:0] go = 12'h000, goe = 12'h000, ein, gin, pad, pin_o, poe;
  int num_errors = 0;
  int total_checks = 0;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} sep_row_s;
  sep_row_s rows[8] = '{'{0, 8'h10, 32'h0, 32'h0}, '{0, 8'h14, 32'h0, 32'h0},
    '{1, 8'h14, 32'hFFFF_FFFF, 32'h0}, '{0, 8'h14, 32'h0, 32'h0000_0FFF},
    '{1, 8'h14, 32'h0, 32'h0}, '{0, 8'h14, 32'h0, 32'h0},
    '{1, 8'h3C, 32'hFFFF_FFFF, 32'h0}, '{0, 8'h3C, 32'h0, 32'h0}};

  always #20 clk_i = ~clk_i;

  // Pad level: pad driver, else the slave, else the pull-up
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      pad[i] = poe[i] ? pin_o[i] : ((i == 8 && hsk_oe) ? hsk_n : 1'b1);
    end
  end

  sep_top #(.TMO_CYC(TMO)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .parity_err_i(par),
    .length_err_i(len), .cs_req_i(csq), .hsk_ready_o(rdy), .master_o(mst),
    .enable_o(en), .eng_out_i(eo), .eng_oe_i(eoe), .eng_in_o(ein),
    .gpio_out_i(go), .gpio_oe_i(goe), .gpio_in_o(gin), .pin_i(pad),
    .pin_o(pin_o), .pin_oe_o(poe));

  sep_slave_model slave (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(pad[0]),
    .answer_i(answer), .hsk_n_o(hsk_n), .hsk_oe_o(hsk_oe));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) chk("bus ack", 32'h0, 32'h1);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic pulse(input bit p);
    @(posedge clk_i);
    if (p) par <= 1'b1; else len <= 1'b1;
    @(posedge clk_i);
    par <= 1'b0; len <= 1'b0;
  endtask

  task automatic stop_test;
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the couple of hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk("reset pads", {poe, pin_o, irq, mst, en, rdy, ack}, 32'h0);
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("row read", q, rows[i].e);
    end
    // Events raise sticky flags and the interrupt
    wb(1, 8'h04, 32'h3);
    #1 chk("ctl bits", {mst, en}, 32'h3);
    wb(1, 8'h24, 32'h4);
    pulse(1);
    wb(0, 8'h10, 0); chk("parity flag", q, 32'h4);
    pulse(0);
    wb(0, 8'h10, 0); chk("length flag", q, 32'h5);
    chk("irq on", irq, 1);
    wb(0, 8'h20, 0); chk("irq status", q, 32'h5);
    #1 chk("irq cleared", irq, 0);
    pulse(0);
    #1 chk("masked irq", irq, 0);
    wb(1, 8'h10, 32'h4);
    wb(0, 8'h10, 0); chk("w1c parity", q, 32'h1);
    // Length event lands on the very edge of its clearing write
    fork
      wb(1, 8'h10, 32'h1);
      begin
        repeat (2) @(posedge clk_i);
        len <= 1'b1;
        @(posedge clk_i);
        len <= 1'b0;
      end
    join
    wb(0, 8'h10, 0); chk("event beats w1c", q, 32'h1);
    // Time-out with a silent slave
    wb(1, 8'h14, 32'h1FF);
    @(posedge clk_i); csq <= 8'h01;
    repeat (3) @(posedge clk_i);
    #1 chk("cs low", {poe[0], pin_o[0]}, 32'h2);
    repeat (TMO + 1) @(posedge clk_i);
    #1 chk("cs released", {pin_o[0], rdy}, 32'h2);
    csq <= 8'h00;
    wb(0, 8'h10, 0); chk("timeout flag", q, 32'h3);
    wb(1, 8'h10, 32'h2);
    // Answering slave: no time-out
    answer <= 1'b1;
    @(posedge clk_i); csq <= 8'h01;
    repeat (TMO + 6) @(posedge clk_i);
    #1 chk("ready", rdy, 1);
    csq <= 8'h00; answer <= 1'b0;
    wb(0, 8'h10, 0); chk("no timeout", q, 32'h1);
    // Slave operation never times out
    wb(1, 8'h04, 32'h2);
    @(posedge clk_i); csq <= 8'h01;
    repeat (TMO + 6) @(posedge clk_i);
    csq <= 8'h00;
    wb(0, 8'h10, 0); chk("slave no timeout", q, 32'h1);
    pulse(1);
    wb(1, 8'h04, 32'h0);
    wb(0, 8'h10, 0); chk("disable clears", q, 32'h0);
    // Routing: GPIO owns everything, then controller takes clock and slave-in
    go <= 12'hA5A; goe <= 12'hFFF; eo <= 4'h4; eoe <= 4'h6;
    wb(1, 8'h14, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk("gpio pins", {poe, pin_o}, 32'hFFF_A5A);
    chk("ctl sees 1", ein, 32'hFFF);
    chk("gpio in", gin, pad);
    wb(1, 8'h14, 32'h600);
    repeat (2) @(posedge clk_i);
    #1 chk("ctl pins", {poe[10:9], pin_o[10:9]}, 32'hE);
    chk("ctl in", ein[10:9], pad[10:9]);
    stop_test();
  end
endmodule

`default_nettype wire
